// ===== hw/insn_decoder.v
// Instruction decoder and executor for 14-bit words, with RMW file access.
// Assumes program memory holds insn_in stable over each four-phase cycle
// and that file reads return data combinationally from file_rdata_in.
//
// Behaviour
// - Instruction is one 14-bit word: opcode, operands.
// - Classify as byte, bit, or literal/control.
// - Destination bit: 0 to accumulator, 1 file.
// - File address spans 0x00 to 0x7F.
// - Bit select picks one of eight bits.
// - Literal is 8 or 11 bits wide.
// - Instruction cycle is four oscillator periods.
// - Taken skip or branch: two cycles, NOP second.
// - File instructions always read, then modify; only bit set/clear and d=1 byte forms write.
// - Clearing the port reads it, clearing mismatch.
// - Don't-care opcode bits change nothing.
`timescale 1ns/100ps
`include "insn_decoder_consts.vh"
module insn_decoder (
  input  wire                        clk_in,          // Oscillator
  input  wire                        reset_n_in,      // Async reset, low
  input  wire [`INSN_WIDTH-1:0]      insn_in,         // Fetched word
  input  wire [`DATA_WIDTH-1:0]      file_rdata_in,   // File read data
  output wire [`FILE_ADDR_WIDTH-1:0] file_addr_out,   // File address
  output wire                        file_rd_out,     // File read strobe
  output reg                         file_wr_out,     // File write strobe
  output reg  [`DATA_WIDTH-1:0]      file_wdata_out,  // File write data
  output wire                        port_read_out,   // Port read, ends mismatch
  output reg  [`DATA_WIDTH-1:0]      w_out,           // Accumulator
  output reg                         carry_out,       // Carry flag
  output reg                         zero_out,        // Zero flag
  output reg                         pc_load_out,     // Load new PC
  output reg  [`LIT11_WIDTH-1:0]     pc_target_out,   // New PC value
  output reg                         call_out,        // Push return
  output reg                         return_out,      // Pop return
  output reg                         sleep_out,       // Enter standby
  output reg                         wdt_clear_out,   // Clear watchdog
  output wire                        fetch_out,       // Advance fetch
  output wire                        stall_nop_out,   // Second cycle as NOP
  output wire [`PHASE_WIDTH-1:0]     phase_out        // Current phase
);
  wire [1:0]                  cls;
  wire [3:0]                  op4;
  wire [1:0]                  bop;
  wire                        dest;
  wire [`FILE_ADDR_WIDTH-1:0] faddr;
  wire [`BIT_SEL_WIDTH-1:0]   bsel;
  wire [`LIT8_WIDTH-1:0]      lit8;
  wire [`LIT11_WIDTH-1:0]     lit11;
  wire                        cycle_end;
  reg                         nop_cycle_reg;
  reg                         nop_cycle_next;
  reg  [`DATA_WIDTH-1:0]      operand_reg;
  reg  [`DATA_WIDTH-1:0]      result;
  reg                         res_c;
  reg                         upd_c;
  reg                         upd_z;
  reg                         to_file;
  reg                         to_w;
  reg                         uses_file;
  reg                         skip;
  reg  [8:0]                  sum;
  wire [`DATA_WIDTH-1:0]      bit_mask;

  insn_field_split u_split (
    .insn_in     (insn_in),
    .class_out   (cls),
    .op4_out     (op4),
    .bop_out     (bop),
    .dest_out    (dest),
    .faddr_out   (faddr),
    .bit_sel_out (bsel),
    .lit8_out    (lit8),
    .lit11_out   (lit11)
  );

  insn_phase_counter u_phase (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .phase_out     (phase_out),
    .cycle_end_out (cycle_end)
  );

  assign bit_mask = 8'h01 << bsel;

  // Decode and compute from the operand latched in the read phase
  always @* begin
    result    = 8'h00;
    res_c     = carry_out;
    upd_c     = 1'b0;
    upd_z     = 1'b0;
    to_file   = 1'b0;
    to_w      = 1'b0;
    uses_file = 1'b0;
    skip      = 1'b0;
    sum       = 9'h000;
    case (cls)
      `CLASS_BYTE: begin
        uses_file = 1'b1;
        to_file   = dest;
        to_w      = ~dest;
        upd_z     = 1'b1;
        case (op4)
          `OP_MOVWF_NOP: begin
            // d=0 forms (NOP, control words) write nothing
            result = w_out;
            upd_z  = 1'b0;
            to_w   = 1'b0;
            uses_file = dest;
          end
          `OP_CLR:    result = 8'h00;
          `OP_SUBWF: begin
            // Carry set means no borrow
            sum    = {1'b0, operand_reg} + {1'b0, ~w_out} + 9'h001;
            result = sum[7:0];
            res_c  = sum[8];
            upd_c  = 1'b1;
          end
          `OP_DECF:   result = operand_reg - 8'h01;
          `OP_IORWF:  result = operand_reg | w_out;
          `OP_ANDWF:  result = operand_reg & w_out;
          `OP_XORWF:  result = operand_reg ^ w_out;
          `OP_ADDWF: begin
            sum    = {1'b0, operand_reg} + {1'b0, w_out};
            result = sum[7:0];
            res_c  = sum[8];
            upd_c  = 1'b1;
          end
          `OP_MOVF:   result = operand_reg;
          `OP_COMF:   result = ~operand_reg;
          `OP_INCF:   result = operand_reg + 8'h01;
          `OP_DECFSZ: begin
            result = operand_reg - 8'h01;
            upd_z  = 1'b0;
            skip   = (result == 8'h00);
          end
          `OP_RRF: begin
            result = {carry_out, operand_reg[7:1]};
            res_c  = operand_reg[0];
            upd_c  = 1'b1;
            upd_z  = 1'b0;
          end
          `OP_RLF: begin
            result = {operand_reg[6:0], carry_out};
            res_c  = operand_reg[7];
            upd_c  = 1'b1;
            upd_z  = 1'b0;
          end
          `OP_SWAPF: begin
            result = {operand_reg[3:0], operand_reg[7:4]};
            upd_z  = 1'b0;
          end
          `OP_INCFSZ: begin
            result = operand_reg + 8'h01;
            upd_z  = 1'b0;
            skip   = (result == 8'h00);
          end
          default:    result = operand_reg;
        endcase
        // Clear-accumulator form writes W regardless of low bits
        if (op4 == `OP_CLR && !dest) begin
          uses_file = 1'b0;
        end
      end
      `CLASS_BIT: begin
        uses_file = 1'b1;
        case (bop)
          `BOP_CLEAR: begin
            result  = operand_reg & ~bit_mask;
            to_file = 1'b1;
          end
          `BOP_SET: begin
            result  = operand_reg | bit_mask;
            to_file = 1'b1;
          end
          `BOP_SKIP_CLR: skip = ~|(operand_reg & bit_mask);
          default:       skip = |(operand_reg & bit_mask);
        endcase
      end
      default: begin
        if (insn_in[13:12] == 2'h3) begin
          to_w  = 1'b1;
          upd_z = 1'b1;
          // Low opcode bits marked don't-care are not examined
          casez (insn_in[11:8])
            4'b00??: begin
              result = lit8;
              upd_z  = 1'b0;
            end
            4'b01??: begin
              result = lit8;
              upd_z  = 1'b0;
            end
            4'b1000: result = lit8 | w_out;
            4'b1001: result = lit8 & w_out;
            4'b1010: result = lit8 ^ w_out;
            4'b110?: begin
              sum    = {1'b0, lit8} + {1'b0, ~w_out} + 9'h001;
              result = sum[7:0];
              res_c  = sum[8];
              upd_c  = 1'b1;
            end
            4'b111?: begin
              sum    = {1'b0, lit8} + {1'b0, w_out};
              result = sum[7:0];
              res_c  = sum[8];
              upd_c  = 1'b1;
            end
            default: begin
              to_w  = 1'b0;
              upd_z = 1'b0;
            end
          endcase
        end
      end
    endcase
  end

  assign file_addr_out = faddr;
  // Read happens even for write-only operations
  assign file_rd_out   = ~nop_cycle_reg & uses_file & (phase_out == `PHASE_READ);
  // Any file op on the port counts, even a pure clear
  assign port_read_out = file_rd_out & (faddr == `IO_PORT_ADDR);
  assign fetch_out     = cycle_end;
  assign stall_nop_out = nop_cycle_reg;

  // Skip decided from the operand latched in phase 0, so this
  // instruction's own file write cannot change the outcome.
  // Stall spans one whole cycle; the word shown then is ignored.
  always @* begin
    nop_cycle_next = 1'b0;
    if (cycle_end && !nop_cycle_reg) begin
      if (skip) begin
        nop_cycle_next = 1'b1;
      end else if (cls == `CLASS_LIT && insn_in[13:12] == 2'h2) begin
        nop_cycle_next = 1'b1;
      end else if (insn_in[13:12] == 2'h3 && insn_in[11:10] == 2'h1) begin
        nop_cycle_next = 1'b1;
      end else if (insn_in == `CW_RETURN || insn_in == `CW_RETFIE) begin
        nop_cycle_next = 1'b1;
      end
    end else if (!cycle_end) begin
      nop_cycle_next = nop_cycle_reg;
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nop_cycle_reg  <= 1'b0;
      operand_reg    <= 8'h00;
      w_out          <= `W_RESET;
      carry_out      <= 1'b0;
      zero_out       <= 1'b0;
      file_wr_out    <= 1'b0;
      file_wdata_out <= 8'h00;
      pc_load_out    <= 1'b0;
      pc_target_out  <= 11'h000;
      call_out       <= 1'b0;
      return_out     <= 1'b0;
      sleep_out      <= 1'b0;
      wdt_clear_out  <= 1'b0;
    end else begin
      nop_cycle_reg <= nop_cycle_next;
      // Pulses default low so each lasts one clock
      file_wr_out   <= 1'b0;
      pc_load_out   <= 1'b0;
      call_out      <= 1'b0;
      return_out    <= 1'b0;
      sleep_out     <= 1'b0;
      wdt_clear_out <= 1'b0;
      if (file_rd_out) begin
        operand_reg <= file_rdata_in;
      end
      // Second cycle of a two-cycle instruction has no effects
      if (!nop_cycle_reg && phase_out == `PHASE_MODIFY) begin
        if (to_w) begin
          w_out <= result;
        end
        if (to_file) begin
          file_wr_out    <= 1'b1;
          file_wdata_out <= result;
        end
        if (upd_c) begin
          carry_out <= res_c;
        end
        if (upd_z) begin
          zero_out <= (result == 8'h00);
        end
        if (insn_in[13:12] == 2'h2) begin
          pc_load_out   <= 1'b1;
          pc_target_out <= lit11;
          call_out      <= ~insn_in[11];
        end
        if (insn_in == `CW_RETURN || insn_in == `CW_RETFIE ||
            (insn_in[13:12] == 2'h3 && insn_in[11:10] == 2'h1)) begin
          return_out <= 1'b1;
        end
        sleep_out     <= (insn_in == `CW_SLEEP);
        wdt_clear_out <= (insn_in == `CW_CLRWDT);
      end
    end
  end
endmodule

// ===== common/insn_decoder_consts.vh
// Constants for the 14-bit instruction decoder and its sequencer.
// Assumes inclusion by bare name from hw/ design files.
`ifndef INSN_DECODER_CONSTS_VH
`define INSN_DECODER_CONSTS_VH
`define INSN_WIDTH        14
`define DATA_WIDTH        8
`define FILE_ADDR_WIDTH   7
`define BIT_SEL_WIDTH     3
`define LIT8_WIDTH        8
`define LIT11_WIDTH       11
`define PHASES_PER_CYCLE  4
`define PHASE_WIDTH       2
`define PHASE_READ        2'h0
`define PHASE_MODIFY      2'h1
`define PHASE_WRITE       2'h2
`define PHASE_FETCH       2'h3
// Instruction classes
`define CLASS_BYTE        2'h0
`define CLASS_BIT         2'h1
`define CLASS_LIT         2'h2
// Field positions
`define CLASS_MSB         13
`define CLASS_LSB         12
`define OP4_MSB           11
`define OP4_LSB           8
`define DEST_POS          7
`define BIT_MSB           9
`define BIT_LSB           7
`define FILE_ADDR_MSB     6
// Byte-oriented 4-bit opcodes
`define OP_MOVWF_NOP      4'h0
`define OP_CLR            4'h1
`define OP_SUBWF          4'h2
`define OP_DECF           4'h3
`define OP_IORWF          4'h4
`define OP_ANDWF          4'h5
`define OP_XORWF          4'h6
`define OP_ADDWF          4'h7
`define OP_MOVF           4'h8
`define OP_COMF           4'h9
`define OP_INCF           4'ha
`define OP_DECFSZ         4'hb
`define OP_RRF            4'hc
`define OP_RLF            4'hd
`define OP_SWAPF          4'he
`define OP_INCFSZ         4'hf
// Bit-oriented 2-bit opcodes
`define BOP_CLEAR         2'h0
`define BOP_SET           2'h1
`define BOP_SKIP_CLR      2'h2
`define BOP_SKIP_SET      2'h3
// Control words with fixed encodings
`define CW_RETURN         14'h0008
`define CW_RETFIE         14'h0009
`define CW_SLEEP          14'h0063
`define CW_CLRWDT         14'h0064
`define IO_PORT_ADDR      7'h06
`define W_RESET           8'h00
`endif

// ===== hw/insn_field_split.v
// Combinational split of a 14-bit word into class and operand fields.
// Assumes the word is stable for the whole instruction cycle.
`timescale 1ns/100ps
`include "insn_decoder_consts.vh"
module insn_field_split (
  input  wire [`INSN_WIDTH-1:0]      insn_in,       // Instruction word
  output reg  [1:0]                  class_out,     // Instruction group
  output wire [3:0]                  op4_out,       // Byte opcode
  output wire [1:0]                  bop_out,       // Bit opcode
  output wire                        dest_out,      // Destination select
  output wire [`FILE_ADDR_WIDTH-1:0] faddr_out,     // File address
  output wire [`BIT_SEL_WIDTH-1:0]   bit_sel_out,   // Bit select
  output wire [`LIT8_WIDTH-1:0]      lit8_out,      // 8-bit literal
  output wire [`LIT11_WIDTH-1:0]     lit11_out      // 11-bit literal
);
  always @* begin
    case (insn_in[`CLASS_MSB:`CLASS_LSB])
      2'h0:    class_out = `CLASS_BYTE;
      2'h1:    class_out = `CLASS_BIT;
      default: class_out = `CLASS_LIT;
    endcase
  end
  assign op4_out     = insn_in[`OP4_MSB:`OP4_LSB];
  assign bop_out     = insn_in[`OP4_MSB:`OP4_MSB-1];
  assign dest_out    = insn_in[`DEST_POS];
  assign faddr_out   = insn_in[`FILE_ADDR_MSB:0];
  assign bit_sel_out = insn_in[`BIT_MSB:`BIT_LSB];
  assign lit8_out    = insn_in[`LIT8_WIDTH-1:0];
  assign lit11_out   = insn_in[`LIT11_WIDTH-1:0];
endmodule

// ===== hw/insn_phase_counter.v
// Divides the oscillator into four-phase instruction cycles.
// Assumes clk_in is the core oscillator.
`timescale 1ns/100ps
`include "insn_decoder_consts.vh"
module insn_phase_counter (
  input  wire                    clk_in,        // Oscillator
  input  wire                    reset_n_in,    // Async reset, low
  output reg  [`PHASE_WIDTH-1:0] phase_out,     // Current phase
  output wire                    cycle_end_out  // Last phase of cycle
);
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_out <= `PHASE_READ;
    end else begin
      phase_out <= phase_out + 2'h1;
    end
  end
  assign cycle_end_out = (phase_out == `PHASE_FETCH);
endmodule

// ===== verification/file_reg_model.sv
// File register space seen from the decoder's data side.
// Assumes reads are answered combinationally and writes land on the clock edge.
`timescale 1ns/100ps
module file_reg_model (
  input  wire logic       clk_in,     // Oscillator
  input  wire logic [6:0] addr_in,    // File address
  input  wire logic       wr_in,      // Write strobe
  input  wire logic [7:0] wdata_in,   // Write data
  output logic      [7:0] rdata_out   // Read data
);
  logic [7:0] mem [0:127];
  // Every address answers, so no floating read is possible
  assign rdata_out = mem[addr_in];
  always @(posedge clk_in) begin
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule

// ===== verification/insn_decoder_asserts.sv
// Timing and field checks on the decoder's ports.
// Assumes a single clock domain with asynchronous active-low reset.
`timescale 1ns/100ps
`include "insn_decoder_consts.vh"
module insn_decoder_checker (
  input wire logic                        clk_in,        // Oscillator
  input wire logic                        reset_n_in,    // Reset, low
  input wire logic [`INSN_WIDTH-1:0]      insn_in,       // Word
  input wire logic [`FILE_ADDR_WIDTH-1:0] file_addr_out, // File address
  input wire logic                        file_rd_out,   // Read strobe
  input wire logic                        file_wr_out,   // Write strobe
  input wire logic                        port_read_out, // Port read
  input wire logic                        pc_load_out,   // PC load
  input wire logic [`LIT11_WIDTH-1:0]     pc_target_out, // PC target
  input wire logic                        fetch_out,     // Fetch
  input wire logic                        stall_nop_out, // NOP cycle
  input wire logic [`PHASE_WIDTH-1:0]     phase_out      // Phase
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  phase_step_a: assert property ($past(reset_n_in) |-> phase_out == $past(phase_out) + 2'h1)
    else $error("phase did not advance by one");
  fetch_phase_a: assert property (fetch_out == (phase_out == 2'h3))
    else $error("fetch outside last phase");
  rd_phase_a: assert property (file_rd_out |-> phase_out == 2'h0)
    else $error("file read outside first phase");
  wr_after_rd_a: assert property (file_wr_out |-> $past(file_rd_out, 2) && phase_out == 2'h2)
    else $error("file write without prior read");
  port_read_a: assert property (port_read_out == (file_rd_out && file_addr_out == 7'h06))
    else $error("port read strobe wrong");
  addr_field_a: assert property (file_addr_out == insn_in[6:0])
    else $error("file address not taken from word");
  dest_file_a: assert property (file_wr_out && insn_in[13:12] == 2'h0 |-> insn_in[7])
    else $error("byte op wrote file with d clear");
  stall_quiet_a: assert property (stall_nop_out |-> !file_wr_out && !pc_load_out && !file_rd_out)
    else $error("activity during NOP cycle");
  stall_len_a: assert property ($rose(stall_nop_out) |-> stall_nop_out[*4] ##1 !stall_nop_out)
    else $error("NOP cycle not four clocks");
  goto_target_a: assert property (pc_load_out && insn_in[13:12] == 2'h2 |-> pc_target_out == insn_in[10:0])
    else $error("branch target not the 11-bit literal");
  cover_write_c: cover property (file_wr_out);
  cover_port_c: cover property (port_read_out);
  cover_stall_c: cover property ($rose(stall_nop_out));
endmodule
bind insn_decoder insn_decoder_checker u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .insn_in(insn_in), .file_addr_out(file_addr_out),
  .file_rd_out(file_rd_out), .file_wr_out(file_wr_out), .port_read_out(port_read_out),
  .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .fetch_out(fetch_out),
  .stall_nop_out(stall_nop_out), .phase_out(phase_out)
);

// ===== verification/fourteen_bit_instruction_decoder_tb_top.sv
// Self-checking bench for the instruction decoder with a file register model.
// Assumes each word is presented right after the edge that starts phase 0.
`timescale 1ns/100ps
module fourteen_bit_instruction_decoder_tb_top;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [13:0] insn_in = 14'h0000;
  logic [7:0]  rdata;
  logic [6:0]  faddr;
  logic        f_rd, f_wr, port_rd, pc_ld, stall;
  logic [7:0]  wdata, w_val;
  logic [10:0] pc_tgt, tgt_seen;
  logic        seen_rd, seen_wr, seen_port, seen_pc, seen_stall;
  logic        carry, zero, call_p, ret_p, sleep_p, wdt_p, fetch;
  logic [1:0]  phase;
  logic        seen_call, seen_ret, seen_sleep, seen_wdt;
  logic [7:0]  phase_seq = 8'h00;
  logic [3:0]  fetch_seq = 4'h0;
  wire  [5:0]  ctl_seen;
  assign ctl_seen = {seen_pc, seen_call, seen_ret, seen_sleep, seen_wdt, seen_stall};
  integer      miscompares = 0;
  integer      checks_done = 0;
  integer      cycles = 0;
  always #50 clk_in = ~clk_in;
  insn_decoder DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .insn_in(insn_in), .file_rdata_in(rdata),
    .file_addr_out(faddr), .file_rd_out(f_rd), .file_wr_out(f_wr), .file_wdata_out(wdata),
    .port_read_out(port_rd), .w_out(w_val), .carry_out(carry), .zero_out(zero), .pc_load_out(pc_ld),
    .pc_target_out(pc_tgt), .call_out(call_p), .return_out(ret_p), .sleep_out(sleep_p), .wdt_clear_out(wdt_p),
    .fetch_out(fetch), .stall_nop_out(stall), .phase_out(phase)
  );
  file_reg_model u_mem (
    .clk_in(clk_in), .addr_in(faddr), .wr_in(f_wr), .wdata_in(wdata), .rdata_out(rdata)
  );
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One full instruction cycle; strobes are collected since pulses last one clock
  task automatic exec(input logic [13:0] word);
    insn_in = word;
    {seen_rd, seen_wr, seen_port, seen_pc, seen_stall} = 5'h00;
    {seen_call, seen_ret, seen_sleep, seen_wdt} = 4'h0;
    repeat (4) begin
      #1;
      seen_call = seen_call | call_p;
      seen_ret = seen_ret | ret_p;
      seen_sleep = seen_sleep | sleep_p;
      seen_wdt = seen_wdt | wdt_p;
      phase_seq = {phase_seq[5:0], phase};
      fetch_seq = {fetch_seq[2:0], fetch};
      seen_rd = seen_rd | f_rd;
      seen_wr = seen_wr | f_wr;
      seen_port = seen_port | port_rd;
      seen_stall = seen_stall | stall;
      if (pc_ld === 1'b1) begin
        seen_pc = 1'b1;
        tgt_seen = pc_tgt;
      end
      @(posedge clk_in);
    end
    #1;
  endtask
  task automatic literal_load;
    exec(14'h335A);
    chk({8'h00, w_val}, 16'h005A);
    chk({14'h0000, seen_rd, seen_wr}, 16'h0000);
  endtask
  task automatic store_to_file;
    exec(14'h00A0);
    chk({14'h0000, seen_rd, seen_wr}, 16'h0003);
    chk({8'h00, u_mem.mem[8'h20]}, 16'h005A);
  endtask
  task automatic add_to_accumulator;
    u_mem.mem[7'h7F] = 8'h10;
    exec(14'h077F);
    chk({8'h00, w_val}, 16'h006A);
    chk({14'h0000, seen_rd, seen_wr}, 16'h0002);
    chk({8'h00, u_mem.mem[7'h7F]}, 16'h0010);
  endtask
  task automatic bit_set_and_skip;
    u_mem.mem[7'h21] = 8'h01;
    exec(14'h17A1);
    chk({8'h00, u_mem.mem[7'h21]}, 16'h0081);
    exec(14'h1FA1);
    chk({15'h0000, seen_wr}, 16'h0000);
    exec(14'h30FF);
    chk({15'h0000, seen_stall}, 16'h0001);
    chk({8'h00, w_val}, 16'h006A);
  endtask
  task automatic branch_taken;
    exec(14'h2FAB);
    chk({15'h0000, seen_pc}, 16'h0001);
    chk({5'h00, tgt_seen}, 16'h07AB);
    exec(14'h0000);
    chk({15'h0000, seen_stall}, 16'h0001);
  endtask
  task automatic clear_port;
    u_mem.mem[7'h06] = 8'hC3;
    exec(14'h0186);
    chk({13'h0000, seen_port, seen_rd, seen_wr}, 16'h0007);
    chk({8'h00, u_mem.mem[7'h06]}, 16'h0000);
  endtask
  task automatic arith_flags;
    exec(14'h3FA0);
    chk({6'h00, carry, zero, w_val}, 16'h020A);
    exec(14'h3C0A);
    chk({6'h00, carry, zero, w_val}, 16'h0300);
    u_mem.mem[7'h22] = 8'h81;
    exec(14'h0DA2);
    chk({6'h00, carry, zero, u_mem.mem[7'h22]}, 16'h0303);
    u_mem.mem[7'h23] = 8'h01;
    exec(14'h0BA3);
    chk({8'h00, u_mem.mem[7'h23]}, 16'h0000);
    exec(14'h3055);
    chk({7'h00, seen_stall, w_val}, 16'h0100);
  endtask
  task automatic control_flow;
    exec(14'h2123);
    chk({10'h000, ctl_seen}, 16'h0030);
    chk({5'h00, tgt_seen}, 16'h0123);
    exec(14'h0000);
    chk({10'h000, ctl_seen}, 16'h0001);
    exec(14'h0008);
    chk({10'h000, ctl_seen}, 16'h0008);
    exec(14'h0000);
    chk({10'h000, ctl_seen}, 16'h0001);
    exec(14'h0063);
    chk({10'h000, ctl_seen}, 16'h0004);
    chk({4'h0, fetch_seq, phase_seq}, 16'h011B);
    exec(14'h0064);
    chk({10'h000, ctl_seen}, 16'h0002);
  endtask
  // Hang guard well above the 90 clocks the sequence needs
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    chk({8'h00, w_val}, 16'h0000);
    literal_load();
    store_to_file();
    add_to_accumulator();
    bit_set_and_skip();
    branch_taken();
    clear_port();
    arith_flags();
    control_flow();
    conclude();
  end
endmodule
